// File: logic/sqsl_pkg.sv
// constants and types for the serial queue setup loader
`default_nettype none
package sqsl_pkg;
   // serial word layout
   localparam int            WORD_BITS     = 26;
   localparam int            QCOUNT_W      = 7;
   localparam int            QUEUES        = 128;
   localparam int            VALUE_W       = 20;
   localparam int            ADDR_FIELD_W  = 13;
   localparam int            COUNT_W       = 14;
   localparam logic [18:0]   HDR_MARK      = 19'h7FFFF;
   localparam logic [4:0]    LAST_BIT      = 5'h19;
   localparam logic [1:0]    WI_FULL       = 2'h0;
   localparam logic [1:0]    WI_EMPTY      = 2'h1;
   localparam logic [1:0]    WI_AFULL      = 2'h2;
   localparam logic [1:0]    WI_ADDR       = 2'h3;
   // stream length per device: header plus spare bit, then four words per queue
   localparam int            BITS_HEADER   = 27;
   localparam int            BITS_QUEUE    = 104;
   // pin synchroniser order and reset image; master reset idles high so aresetn makes no false release
   localparam int            PIN_MRESET    = 4;
   localparam int            PIN_MODE      = 3;
   localparam int            PIN_SCLK      = 2;
   localparam int            PIN_SI        = 1;
   localparam int            PIN_EN_N      = 0;
   localparam logic [4:0]    PIN_RESET     = 5'h11;
   // register bus
   localparam int            AXI_ADDR_W    = 8;
   localparam logic [7:0]    OFS_STATUS    = 8'h00;
   localparam logic [7:0]    OFS_BITCOUNT  = 8'h04;
   localparam logic [7:0]    OFS_QSEL      = 8'h08;
   localparam logic [7:0]    OFS_FULL      = 8'h0C;
   localparam logic [7:0]    OFS_EMPTY     = 8'h10;
   localparam logic [7:0]    OFS_AFULL     = 8'h14;
   localparam logic [7:0]    OFS_ADDR      = 8'h18;
   localparam logic [7:0]    OFS_CTRL      = 8'h1C;
   localparam int            ST_DONE_BIT   = 0;
   localparam int            ST_ERR_BIT    = 1;
   localparam int            ST_SERIAL_BIT = 2;
   localparam int            ST_QCOUNT_LSB = 8;
   localparam int            CTRL_CLR_BIT  = 0;
   localparam logic [6:0]    QSEL_RESET    = 7'h00;
   localparam logic [1:0]    RESP_OKAY     = 2'h0;
   localparam logic [1:0]    RESP_SLVERR   = 2'h2;

   typedef enum {SQ_HOLD, SQ_HEADER, SQ_SPARE, SQ_QUEUE, SQ_DONE} sqsl_state_type;
endpackage : sqsl_pkg
`default_nettype wire

// File: logic/sqsl_loader.sv
// serial setup loader with pass-through and register readback
// Functional notes
// - default mode low: wait for serial load
// - capture data on enabled serial clock rise
// - one device takes 27+104*Q enabled bits
// - out enable goes low when load complete
// - programmed: out enable follows in enable
// - programmed: serial data passes straight through
// - stream is 26-bit header, spare bit, then 4 words/queue
// - header: marker ones 25:7, count 6:0
// - word two: full value, top bits zero
// - word three: almost-empty count bits 19:0
// - word four: almost-full encoded bits 19:0
// - independent setup set for up to 127 queues
// - address word: end 25:13, start 12:0
`timescale 1ns/1ps
`default_nettype none
module sqsl_loader
   import sqsl_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // device pins
   input  wire logic                  master_reset_n,
   input  wire logic                  default_mode_select,
   input  wire logic                  serial_clk,
   input  wire logic                  serial_in,
   input  wire logic                  serial_in_enable_n,
   output logic                       serial_out,
   output logic                       serial_out_enable_n,
   // to the queue logic
   output logic                       setup_done,
   // axi4-lite write
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [AXI_ADDR_W-1:0] awaddr,
   input  wire logic                  wvalid,
   output logic                       wready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   output logic                       bvalid,
   input  wire logic                  bready,
   output logic [1:0]                 bresp,
   // axi4-lite read
   input  wire logic                  arvalid,
   output logic                       arready,
   input  wire logic [AXI_ADDR_W-1:0] araddr,
   output logic                       rvalid,
   input  wire logic                  rready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp
);

   function automatic logic [COUNT_W-1:0] bits_total(input logic [QCOUNT_W-1:0] q);
      bits_total = COUNT_W'(BITS_HEADER + BITS_QUEUE * int'(q));
   endfunction : bits_total

   function automatic logic ofs_mapped(input logic [AXI_ADDR_W-1:0] a);
      ofs_mapped = (a == OFS_STATUS) || (a == OFS_BITCOUNT) || (a == OFS_QSEL) ||
                   (a == OFS_FULL) || (a == OFS_EMPTY) || (a == OFS_AFULL) ||
                   (a == OFS_ADDR) || (a == OFS_CTRL);
   endfunction : ofs_mapped

   logic [4:0]               pin_s1;
   logic [4:0]               pin_s2;
   logic                     sclk_prev;
   logic                     mreset_prev;
   logic                     sclk_rise;
   logic                     mreset_rise;
   logic                     accept;
   logic                     word_end;
   logic [WORD_BITS-1:0]     next_word;
   sqsl_state_type           state;
   logic [WORD_BITS-2:0]     shift;
   logic [4:0]               bit_in_word;
   logic [1:0]               word_idx;
   logic [QCOUNT_W-1:0]      queue_idx;
   logic [QCOUNT_W-1:0]      queue_count;
   logic [COUNT_W-1:0]       bit_count;
   logic                     serial_mode;
   logic                     header_error;
   logic                     header_bad;
   logic                     done;
   logic [VALUE_W-1:0]       full_mem  [0:QUEUES-1];
   logic [VALUE_W-1:0]       empty_mem [0:QUEUES-1];
   logic [VALUE_W-1:0]       afull_mem [0:QUEUES-1];
   logic [WORD_BITS-1:0]     addr_mem  [0:QUEUES-1];
   logic                     aw_held;
   logic                     w_held;
   logic [AXI_ADDR_W-1:0]    aw_addr_q;
   logic [31:0]              w_data_q;
   logic [3:0]               w_strb_q;
   logic                     wr_fire;
   logic                     err_clear;
   logic [QCOUNT_W-1:0]      queue_sel;
   logic [31:0]              read_value;

   // pins are asynchronous to aclk; only the second stage is used
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1      <= PIN_RESET;
         pin_s2      <= PIN_RESET;
         sclk_prev   <= 1'b0;
         mreset_prev <= 1'b1;
      end else begin
         pin_s1      <= {master_reset_n, default_mode_select, serial_clk, serial_in, serial_in_enable_n};
         pin_s2      <= pin_s1;
         sclk_prev   <= pin_s2[PIN_SCLK];
         mreset_prev <= pin_s2[PIN_MRESET];
      end
   end

   // data and enable share the clock's synchroniser delay, so they stay aligned
   assign sclk_rise = pin_s2[PIN_SCLK] & ~sclk_prev;
   assign mreset_rise = pin_s2[PIN_MRESET] & ~mreset_prev;
   assign accept    = sclk_rise & ~pin_s2[PIN_EN_N] & pin_s2[PIN_MRESET] &
                      ((state == SQ_HEADER) || (state == SQ_SPARE) || (state == SQ_QUEUE));
   assign word_end  = (bit_in_word == LAST_BIT);
   assign next_word = {shift, pin_s2[PIN_SI]};
   assign header_bad = accept && (state == SQ_HEADER) && word_end &&
                       (next_word[WORD_BITS-1:QCOUNT_W] != HDR_MARK);
   assign done = (state == SQ_DONE);

   // stream sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state       <= SQ_HOLD;
         shift       <= '0;
         bit_in_word <= 5'h00;
         word_idx    <= WI_FULL;
         queue_idx   <= 7'h00;
         queue_count <= 7'h00;
         bit_count   <= 14'h0000;
         serial_mode <= 1'b0;
      end else if (!pin_s2[PIN_MRESET]) begin
         state       <= SQ_HOLD;
         bit_in_word <= 5'h00;
         word_idx    <= WI_FULL;
         queue_idx   <= 7'h00;
         bit_count   <= 14'h0000;
      end else if (mreset_rise) begin
         // mode is caught on the master reset release
         serial_mode <= ~pin_s2[PIN_MODE];
         state       <= pin_s2[PIN_MODE] ? SQ_DONE : SQ_HEADER;
      end else if (accept) begin
         shift       <= next_word[WORD_BITS-2:0];
         bit_count   <= bit_count + 14'h0001;
         bit_in_word <= word_end ? 5'h00 : bit_in_word + 5'h01;
         case (state)
            SQ_HEADER: begin
               if (word_end) begin
                  if (header_bad) begin
                     // hunt for a fresh header instead of loading garbage
                     bit_count <= 14'h0000;
                  end else begin
                     queue_count <= next_word[QCOUNT_W-1:0];
                     state       <= SQ_SPARE;
                  end
               end
            end
            SQ_SPARE: begin
               bit_in_word <= 5'h00;
               state       <= (queue_count == 7'h00) ? SQ_DONE : SQ_QUEUE;
            end
            SQ_QUEUE: begin
               if (word_end) begin
                  word_idx <= word_idx + 2'h1;
                  if (word_idx == WI_ADDR) begin
                     if (queue_idx == queue_count - 7'h01) begin
                        state <= SQ_DONE;
                     end else begin
                        queue_idx <= queue_idx + 7'h01;
                     end
                  end
               end
            end
            default: begin
               state <= state;
            end
         endcase
      end
   end

   // per-queue setup storage
   always_ff @(posedge aclk) begin
      if (accept && (state == SQ_QUEUE) && word_end) begin
         case (word_idx)
            WI_FULL:  full_mem[queue_idx]  <= next_word[VALUE_W-1:0];
            WI_EMPTY: empty_mem[queue_idx] <= next_word[VALUE_W-1:0];
            WI_AFULL: afull_mem[queue_idx] <= next_word[VALUE_W-1:0];
            default:  addr_mem[queue_idx]  <= next_word;
         endcase
      end
   end

   // header fault flag; a new fault beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         header_error <= 1'b0;
      end else if (header_bad) begin
         header_error <= 1'b1;
      end else if (err_clear) begin
         header_error <= 1'b0;
      end
   end

   // outputs; after loading the chain sees our inputs three aclk later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_out_enable_n <= 1'b1;
         serial_out          <= 1'b0;
         setup_done          <= 1'b0;
      end else begin
         serial_out_enable_n <= done ? pin_s2[PIN_EN_N] : 1'b1;
         serial_out          <= done ? pin_s2[PIN_SI] : 1'b0;
         setup_done          <= done;
      end
   end

   // axi4-lite write: address and data taken in any order, answered together
   assign awready   = ~aw_held;
   assign wready    = ~w_held;
   assign wr_fire   = aw_held & w_held & ~bvalid;
   assign err_clear = wr_fire && (aw_addr_q == OFS_CTRL) && w_strb_q[0] && w_data_q[CTRL_CLR_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_held   <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= ofs_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // readback selector steers which queue the data registers show
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         queue_sel <= QSEL_RESET;
      end else if (wr_fire && (aw_addr_q == OFS_QSEL) && w_strb_q[0]) begin
         queue_sel <= w_data_q[QCOUNT_W-1:0];
      end
   end

   always_comb begin
      read_value = 32'h00000000;
      case (araddr)
         OFS_STATUS: begin
            read_value[ST_DONE_BIT]   = done;
            read_value[ST_ERR_BIT]    = header_error;
            read_value[ST_SERIAL_BIT] = serial_mode;
            read_value[ST_QCOUNT_LSB +: QCOUNT_W] = queue_count;
         end
         OFS_BITCOUNT: read_value[COUNT_W-1:0]   = bit_count;
         OFS_QSEL:     read_value[QCOUNT_W-1:0]  = queue_sel;
         OFS_FULL:     read_value[VALUE_W-1:0]   = full_mem[queue_sel];
         OFS_EMPTY:    read_value[VALUE_W-1:0]   = empty_mem[queue_sel];
         OFS_AFULL:    read_value[VALUE_W-1:0]   = afull_mem[queue_sel];
         OFS_ADDR:     read_value[WORD_BITS-1:0] = addr_mem[queue_sel];
         default:      read_value = 32'h00000000;
      endcase
   end

   // axi4-lite read: one beat, answered the cycle after acceptance
   assign arready = ~rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= read_value;
         rresp  <= ofs_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // checks
   property p_count_at_done;
      @(posedge aclk) disable iff (!aresetn)
      $rose(done) && serial_mode |-> bit_count == bits_total(queue_count);
   endproperty
   a_count_at_done: assert property (p_count_at_done) else $error("bit count wrong at completion");

   property p_count_only_on_enabled_edge;
      @(posedge aclk) disable iff (!aresetn)
      (bit_count > $past(bit_count)) |-> $past(sclk_rise) && !$past(pin_s2[PIN_EN_N]);
   endproperty
   a_count_only_on_enabled_edge: assert property (p_count_only_on_enabled_edge) else $error("bit taken without enable");

   property p_enable_high_before_done;
      @(posedge aclk) disable iff (!aresetn)
      !done |=> serial_out_enable_n;
   endproperty
   a_enable_high_before_done: assert property (p_enable_high_before_done) else $error("out enable low too early");

   property p_enable_follows;
      @(posedge aclk) disable iff (!aresetn)
      done ##1 done |-> serial_out_enable_n == $past(pin_s2[PIN_EN_N]);
   endproperty
   a_enable_follows: assert property (p_enable_follows) else $error("out enable not following");

   property p_data_follows;
      @(posedge aclk) disable iff (!aresetn)
      done ##1 done |-> serial_out == $past(pin_s2[PIN_SI]);
   endproperty
   a_data_follows: assert property (p_data_follows) else $error("serial data not passed through");

   property p_bad_header_flag;
      @(posedge aclk) disable iff (!aresetn)
      header_bad |=> header_error && (state == SQ_HEADER) && (bit_count == 14'h0000);
   endproperty
   a_bad_header_flag: assert property (p_bad_header_flag) else $error("bad header not caught");

   property p_full_stored;
      @(posedge aclk) disable iff (!aresetn)
      accept && (state == SQ_QUEUE) && word_end && (word_idx == WI_FULL) && pin_s2[PIN_MRESET]
      |=> full_mem[$past(queue_idx)] == $past(next_word[VALUE_W-1:0]);
   endproperty
   a_full_stored: assert property (p_full_stored) else $error("full value not stored");

   property p_reset_unloads;
      @(posedge aclk) disable iff (!aresetn)
      !pin_s2[PIN_MRESET] |=> !done ##1 serial_out_enable_n;
   endproperty
   a_reset_unloads: assert property (p_reset_unloads) else $error("master reset did not clear load");

   property p_ready_tracks;
      @(posedge aclk) disable iff (!aresetn)
      $rose(setup_done) |-> $past(done) && !serial_out_enable_n == !$past(pin_s2[PIN_EN_N]);
   endproperty
   a_ready_tracks: assert property (p_ready_tracks) else $error("ready not aligned with completion");

endmodule : sqsl_loader
`default_nettype wire

// File: dv/sqsl_host_model.sv
// host side of the serial setup link
`timescale 1ns/1ps
`default_nettype none
module sqsl_host_model (
   // serial pins towards the device
   output logic serial_clk,
   output logic serial_in,
   output logic serial_in_enable_n
);
   // single device: the chain is one long, so its own enable output marks completion
   initial begin
      serial_clk         = 1'b0;
      serial_in          = 1'b0;
      serial_in_enable_n = 1'b1;
   end

   // clock stands low between frames; n low bits of w go msb first
   task automatic send(input logic [25:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_in          <= w[i];
         serial_in_enable_n <= 1'b0;
         #31.25 serial_clk <= 1'b1;
         #62.5 serial_clk <= 1'b0;
         #31.25;
      end
   endtask : send

   // stop and release; data line shows the inverse, not a stale bit
   task automatic release_en();
      serial_in_enable_n <= 1'b1;
      serial_in          <= ~serial_in;
   endtask : release_en

   // clocks with the enable high must not be counted
   task automatic idle_clocks(input int n);
      serial_in_enable_n <= 1'b1;
      for (int i = 0; i < n; i++) begin
         serial_in <= ~serial_in;
         #31.25 serial_clk <= 1'b1;
         #62.5 serial_clk <= 1'b0;
         #31.25;
      end
   endtask : idle_clocks

   task automatic drive(input logic en_n, input logic d);
      serial_in_enable_n <= en_n;
      serial_in          <= d;
   endtask : drive
endmodule : sqsl_host_model
`default_nettype wire

// File: dv/test_serial_queue_setup_loader.sv
// testbench for the serial queue setup loader
`timescale 1ns/1ps
`default_nettype none
module test_serial_queue_setup_loader;
   import sqsl_pkg::*;
   logic                  aclk, aresetn, master_reset_n, default_mode_select;
   wire logic             serial_clk, serial_in, serial_in_enable_n;
   logic                  serial_out, serial_out_enable_n, setup_done;
   logic                  awvalid, awready, wvalid, wready, bvalid, bready;
   logic                  arvalid, arready, rvalid, rready;
   logic [AXI_ADDR_W-1:0] awaddr, araddr;
   logic [31:0]           wdata, rdata, rd;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp, rs;
   int                    mismatches, n_tests;
   // two queues: full, almost-empty, almost-full, address word
   localparam logic [25:0] QW [2][4] = '{'{26'h0003FFE, 26'h0000034, 26'h0003FD9, 26'h001E000},
                                         '{26'h00003FE, 26'h0000005, 26'h00003F9, 26'h0020100}};

   sqsl_loader i_sqsl_loader (.aclk(aclk), .aresetn(aresetn), .master_reset_n(master_reset_n),
      .default_mode_select(default_mode_select), .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_in_enable_n(serial_in_enable_n), .serial_out(serial_out),
      .serial_out_enable_n(serial_out_enable_n), .setup_done(setup_done), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp));
   sqsl_host_model i_sqsl_host_model (.serial_clk(serial_clk), .serial_in(serial_in),
      .serial_in_enable_n(serial_in_enable_n));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop();
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // requests start on a fresh rising edge, so back-to-back calls never drive a signal twice in one step;
   // handshakes are judged on the values seen at the rising edge, answers taken at that same edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   // pin crosses two synchronisers, so allow a bounded settle
   task automatic wait_pin(input bit sel, input logic v, input string nm);
      int k;
      k = 0;
      while (((sel ? serial_out : serial_out_enable_n) !== v) && k < 20) begin
         @(posedge aclk);
         k++;
      end
      chk(nm, sel ? serial_out : serial_out_enable_n, v);
   endtask : wait_pin

   task automatic mreset(input logic mode);
      @(posedge aclk);
      master_reset_n      <= 1'b0;
      default_mode_select <= mode;
      repeat (5) @(posedge aclk);
      chk("reset out_enable_n", serial_out_enable_n, 1'b1);
      master_reset_n <= 1'b1;
      repeat (8) @(posedge aclk);
   endtask : mreset

   initial begin
      #300000;
      mismatches++;
      report_and_stop();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, default_mode_select} = '0;
      master_reset_n = 1'b1;
      awaddr         = '0;
      araddr         = '0;
      wdata          = '0;
      wstrb          = 4'hF;
      mismatches     = 0;
      n_tests        = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      mreset(1'b0);
      chk("setup_done", setup_done, 1'b0);
      chk("out_enable_n", serial_out_enable_n, 1'b1);
      axr(OFS_QSEL, rd, rs);
      chk("qsel reset", rd[6:0], QSEL_RESET);
      i_sqsl_host_model.idle_clocks(4);
      axr(OFS_BITCOUNT, rd, rs);
      chk("bitcount idle", rd[13:0], 14'h0000);
      i_sqsl_host_model.send({1'b0, 18'h3FFFF, 7'h02}, 26);
      i_sqsl_host_model.release_en();
      repeat (8) @(posedge aclk);
      axr(OFS_STATUS, rd, rs);
      chk("header_error", rd[ST_ERR_BIT], 1'b1);
      axw(OFS_CTRL, 32'h0000_0001, rs);
      axr(OFS_STATUS, rd, rs);
      chk("header_error clear", rd[ST_ERR_BIT], 1'b0);
      mreset(1'b0);
      // header, spare bit, then all but the very last bit
      i_sqsl_host_model.send({HDR_MARK, 7'h02}, 26);
      i_sqsl_host_model.send(26'h0, 1);
      for (int q = 0; q < 2; q++) begin
         for (int w = 0; w < 4; w++) begin
            if (q == 1 && w == 3) i_sqsl_host_model.send(QW[q][w] >> 1, 25);
            else i_sqsl_host_model.send(QW[q][w], 26);
         end
      end
      repeat (10) @(posedge aclk);
      chk("out_enable_n early", serial_out_enable_n, 1'b1);
      chk("setup_done early", setup_done, 1'b0);
      i_sqsl_host_model.send(QW[1][3], 1);
      wait_pin(1'b0, 1'b0, "out_enable_n done");
      repeat (2) @(posedge aclk);
      chk("setup_done", setup_done, 1'b1);
      i_sqsl_host_model.release_en();
      wait_pin(1'b0, 1'b1, "out_enable_n follow high");
      i_sqsl_host_model.drive(1'b0, 1'b1);
      wait_pin(1'b0, 1'b0, "out_enable_n follow low");
      wait_pin(1'b1, 1'b1, "serial_out one");
      i_sqsl_host_model.drive(1'b0, 1'b0);
      wait_pin(1'b1, 1'b0, "serial_out zero");
      axr(OFS_STATUS, rd, rs);
      chk("status qcount", rd[ST_QCOUNT_LSB +: 7], 7'h02);
      chk("status flags", rd[2:0], 3'b101);
      axr(OFS_BITCOUNT, rd, rs);
      chk("bitcount", rd[13:0], 14'(27 + 104 * 2));
      // each queue holds its own set of words
      for (int q = 0; q < 2; q++) begin
         axw(OFS_QSEL, 32'(q), rs);
         axr(OFS_QSEL, rd, rs);
         chk("qsel", rd[6:0], 7'(q));
         for (int w = 0; w < 4; w++) begin
            axr(OFS_FULL + 8'(4 * w), rd, rs);
            chk("setup word", w == 3 ? rd[25:0] : rd[19:0], w == 3 ? QW[q][w] : QW[q][w][19:0]);
         end
      end
      axr(8'h20, rd, rs);
      chk("read unmapped", rs, RESP_SLVERR);
      axw(8'h24, 32'h0, rs);
      chk("write unmapped", rs, RESP_SLVERR);
      axw(OFS_STATUS, 32'h0, rs);
      chk("write ro resp", rs, RESP_OKAY);
      axr(OFS_STATUS, rd, rs);
      chk("write ro ignored", rd[ST_DONE_BIT], 1'b1);
      // zero queues: header and spare bit only
      mreset(1'b0);
      i_sqsl_host_model.send({HDR_MARK, 7'h00}, 26);
      i_sqsl_host_model.send(26'h0, 1);
      wait_pin(1'b0, 1'b0, "zero queue done");
      axr(OFS_BITCOUNT, rd, rs);
      chk("bitcount zero", rd[13:0], 14'(27));
      // strap high skips serial loading
      i_sqsl_host_model.drive(1'b0, 1'b0);
      mreset(1'b1);
      wait_pin(1'b0, 1'b0, "default out_enable_n");
      axr(OFS_STATUS, rd, rs);
      chk("default serial flag", rd[ST_SERIAL_BIT], 1'b0);
      report_and_stop();
   end
endmodule : test_serial_queue_setup_loader
`default_nettype wire
